// [oversampling_pkg.sv]
// Package: shared constants and types of the oversampling capture link
package oversampling_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int unsigned SAMPLE_W      = 32;
    localparam int unsigned TIME_W        = 64;
    localparam int unsigned FACTOR_W      = 7;
    localparam int unsigned MAX_FACTOR    = 100;
    localparam int unsigned INDEX_W       = 7;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MIN_SAMPLE_PERIOD_US = 10;
    localparam int unsigned MIN_SAMPLE_PERIOD_NS = MIN_SAMPLE_PERIOD_US * 1000;
    localparam int unsigned MIN_CYCLE_US  = 500;
    localparam int unsigned MIN_CYCLE_NS  = MIN_CYCLE_US * 1000;
    localparam logic [TIME_W-1:0] TIME_STEP_NS = 64'h0000_0000_0000_0064;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [FACTOR_W-1:0] FACTOR_RESET   = 7'h01;
    localparam logic [31:0]         CYCLE_NS_RESET = 32'h000f_4240;
    localparam logic                STAMP_EN_RESET = 1'b1;

    typedef logic [SAMPLE_W-1:0] sample_t;
    typedef logic [TIME_W-1:0]   time_t;

endpackage : oversampling_pkg

// [os_link_if.sv]
// Interface: process data link between capture node and bus master
`timescale 1ns/1ps
interface os_link_if;
    import oversampling_pkg::*;

    logic                  packet_valid;    // One-cycle pulse, packet published
    logic                  data_ok;         // Packet carries valid data
    logic [FACTOR_W-1:0]   sample_count;    // Samples in packet
    sample_t               samples [MAX_FACTOR];
    logic                  stamp_valid;     // Timestamp item enabled
    time_t                 next_cycle_start_time;
    time_t                 master_time;     // Reference time from master
    logic                  time_load;       // Pulse, load master_time

    modport node   (output packet_valid, data_ok, sample_count, samples,
                    stamp_valid, next_cycle_start_time,
                    input master_time, time_load);
    modport master (input packet_valid, data_ok, sample_count, samples,
                    stamp_valid, next_cycle_start_time,
                    output master_time, time_load);
endinterface : os_link_if

// [tick_gen.sv]
// Tick generator: cycle and sample ticks from the local time base
`timescale 1ns/1ps
module tick_gen
    import oversampling_pkg::*;
(
    input  wire logic               clk,         // Clock
    input  wire logic               rst,         // Sync reset
    input  wire logic [31:0]        cycle_ns,    // Cycle time
    input  wire logic [31:0]        sample_ns,   // Sample period
    input  wire logic               run,         // Config plausible
    input  wire logic               time_load,   // Realign pulse
    input  wire time_t              time_now,    // Local time base
    output logic                    cycle_tick,  // Pulse per cycle
    output logic                    sample_tick  // Pulse per sample
);
    typedef struct packed {
        logic [31:0] cyc_left;
        logic [31:0] smp_left;
        logic        cyc;
        logic        smp;
    } tick_s;

    tick_s st;
    tick_s next_st;

    localparam logic [31:0] STEP32 = TIME_STEP_NS[31:0];

    always_comb
    begin
        next_st     = st;
        next_st.cyc = 1'b0;
        next_st.smp = 1'b0;
        if (!run || time_load)
        begin
            // Phase restarts at cycle start so equal nodes sample together
            next_st.cyc_left = cycle_ns - 32'(time_now % 64'(cycle_ns));
            next_st.smp_left = sample_ns;
        end
        else if (st.cyc_left <= STEP32)
        begin
            next_st.cyc      = 1'b1;
            next_st.smp      = 1'b1;
            next_st.cyc_left = cycle_ns;
            next_st.smp_left = sample_ns;
        end
        else
        begin
            next_st.cyc_left = st.cyc_left - STEP32;
            if (st.smp_left <= STEP32)
            begin
                next_st.smp      = 1'b1;
                next_st.smp_left = sample_ns;
            end
            else
            begin
                next_st.smp_left = st.smp_left - STEP32;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{cyc_left: CYCLE_NS_RESET, smp_left: CYCLE_NS_RESET,
                    cyc: 1'b0, smp: 1'b0};
        else
            st <= next_st;
    end

    assign cycle_tick  = st.cyc;
    assign sample_tick = st.smp;
endmodule // tick_gen

// [capture_node.sv]
// Capture node: oversampled encoder counter buffer with cycle timestamp
//
// What this block does
// - Capture counter n equidistant times per cycle
// - Publish packet of 32-bit samples next cycle
// - Local time counts 1 ns, 64 bits
// - Master keeps local time within 100 ns
// - Cycle tick once per bus cycle
// - Sample tick at n times cycle rate
// - Each sample tick stores counter, next slot
// - Configurer keeps sample period at least 10 us
// - Configurer keeps cycle time at least 500 us
// - Sample period must be whole nanoseconds
// - Implausible config: run, but no data
// - Sample ticks phase aligned to cycle tick
// - Cycle tick publishes buffer, latches next start
// - Packet carries next cycle start time, not this cycle's start
// - Timestamp item 64 bits, enabled by default
// - Factor resets to one, sets sample count
// - Timestamp advances one cycle time each cycle
`timescale 1ns/1ps
module capture_node
    import oversampling_pkg::*;
(
    input  wire logic                clk,          // Clock
    input  wire logic                rst,          // Sync reset
    input  wire sample_t             counter,      // Encoder counter value
    input  wire logic [FACTOR_W-1:0] factor,       // Oversampling factor n
    input  wire logic [31:0]         cycle_ns,     // Bus cycle time in ns
    input  wire logic                stamp_en,     // Timestamp item enable
    output logic                     op_state,     // Node in operational state
    os_link_if.node                  link          // Process data link
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        time_t                now;
        time_t                next_start;
        logic [INDEX_W-1:0]   wr_idx;
        logic [FACTOR_W-1:0]  n_act;
        logic [FACTOR_W-1:0]  pkt_n;
        logic [31:0]          cyc_act;
        logic [31:0]          smp_act;
        logic                 plausible;
        logic                 stamp;
        logic                 pub;
        logic                 ok;
        logic                 op;
        logic                 primed;
    } node_s;

    node_s   st;
    node_s   next_st;
    sample_t buf_mem [MAX_FACTOR];
    sample_t out_mem [MAX_FACTOR];
    logic    cycle_tick;
    logic    sample_tick;

    // ------------------------------------------------------------------
    // Configuration check
    // ------------------------------------------------------------------
    // A bad set stops the ticks: the node stays up but sends no data
    function automatic logic config_ok(input logic [FACTOR_W-1:0] n,
                                       input logic [31:0] cyc);
        logic ok;
        ok = 1'b1;
        if (n == '0 || 32'(n) > MAX_FACTOR)
            ok = 1'b0;
        else if (cyc < MIN_CYCLE_NS)
            ok = 1'b0;
        else if ((cyc % 32'(n)) != '0)
            ok = 1'b0;
        else if ((cyc / 32'(n)) < MIN_SAMPLE_PERIOD_NS)
            ok = 1'b0;
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------------
    // Fed the time that holds after this edge, so a realign lands on it
    tick_gen i_tick_gen (
        .clk         (clk),
        .rst         (rst),
        .cycle_ns    (st.cyc_act),
        .sample_ns   (st.smp_act),
        .run         (st.plausible),
        .time_load   (link.time_load),
        .time_now    (next_st.now),
        .cycle_tick  (cycle_tick),
        .sample_tick (sample_tick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st     = st;
        next_st.pub = 1'b0;
        next_st.op  = 1'b1;
        // Local time base, realigned by the master
        if (link.time_load)
            next_st.now = link.master_time;
        else
            next_st.now = st.now + TIME_STEP_NS;
        // Config is taken only at a cycle boundary or while stopped
        if (cycle_tick || !st.plausible)
        begin
            next_st.n_act     = factor;
            next_st.cyc_act   = cycle_ns;
            next_st.smp_act   = config_ok(factor, cycle_ns) ?
                                cycle_ns / 32'(factor) : CYCLE_NS_RESET;
            next_st.plausible = config_ok(factor, cycle_ns);
            next_st.stamp     = stamp_en;
        end
        if (sample_tick && !cycle_tick && 32'(st.wr_idx) < MAX_FACTOR)
            next_st.wr_idx = st.wr_idx + 7'h01;
        if (cycle_tick)
        begin
            // Slot 0 is taken by this tick, the next sample goes to slot 1
            next_st.wr_idx = 7'h01;
            next_st.primed = 1'b1;
        end
        // Only a block sampled over a whole cycle is published
        if (cycle_tick && st.primed)
        begin
            next_st.pub        = 1'b1;
            next_st.ok         = st.plausible;
            next_st.pkt_n      = st.n_act;
            // Stamp is the start of the next block
            next_st.next_start = st.now + TIME_W'(st.cyc_act);
        end
        // Realign moves the tick phase, so the block in flight is dropped
        if (link.time_load)
        begin
            next_st.primed = 1'b0;
            next_st.wr_idx = '0;
        end
        if (!st.plausible)
        begin
            next_st.primed = 1'b0;
            next_st.ok     = 1'b0;
            next_st.wr_idx = '0;
        end
        // A disabled stamp reads as zero, never as a stale time
        if (!next_st.stamp)
            next_st.next_start = '0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{now:        '0,
                    next_start: '0,
                    wr_idx:     '0,
                    n_act:      FACTOR_RESET,
                    pkt_n:      FACTOR_RESET,
                    cyc_act:    CYCLE_NS_RESET,
                    smp_act:    CYCLE_NS_RESET,
                    plausible:  1'b0,
                    stamp:      STAMP_EN_RESET,
                    pub:        1'b0,
                    ok:         1'b0,
                    op:         1'b0,
                    primed:     1'b0};
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // Sample buffer and published copy
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < MAX_FACTOR; gi++)
        begin : g_slot
            // Cycle tick captures the first sample of the new block too
            always_ff @(posedge clk)
            begin
                if (rst)
                    buf_mem[gi] <= '0;
                else if (sample_tick && (cycle_tick ? gi == 0 : 32'(st.wr_idx) == gi))
                    buf_mem[gi] <= counter;
            end
            always_ff @(posedge clk)
            begin
                if (rst)
                    out_mem[gi] <= '0;
                else if (cycle_tick && st.plausible && st.primed)
                    out_mem[gi] <= (gi < 32'(st.n_act)) ? buf_mem[gi] : '0;
            end
            assign link.samples[gi] = out_mem[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs, all straight from registers
    // ------------------------------------------------------------------
    // Count travels with its packet, not with a factor changed meanwhile
    assign link.packet_valid          = st.pub;
    assign link.data_ok               = st.ok;
    assign link.sample_count          = st.pkt_n;
    assign link.stamp_valid           = st.stamp;
    assign link.next_cycle_start_time = st.next_start;
    assign op_state                   = st.op;
endmodule // capture_node

// [bus_master.sv]
// Bus master end: keeps node time aligned and collects packets
`timescale 1ns/1ps
module bus_master
    import oversampling_pkg::*;
(
    input  wire logic                clk,         // Clock
    input  wire logic                rst,         // Sync reset
    input  wire time_t               ref_time,    // Master reference clock
    input  wire logic                sync_req,    // Request time alignment
    output logic                     pkt_strobe,  // Packet received pulse
    output logic                     pkt_ok,      // Received packet valid
    output logic [FACTOR_W-1:0]      pkt_count,   // Samples in packet
    output time_t                    pkt_time,    // Next cycle start time
    output sample_t                  first_sample,// First sample of packet
    os_link_if.master                link         // Process data link
);
    typedef struct packed {
        time_t               mt;
        logic                load;
        logic                strobe;
        logic                ok;
        logic [FACTOR_W-1:0] cnt;
        time_t               ts;
        sample_t             s0;
    } master_s;

    master_s st;
    master_s next_st;

    always_comb
    begin
        next_st        = st;
        next_st.load   = sync_req;
        next_st.mt     = ref_time + TIME_STEP_NS;
        next_st.strobe = link.packet_valid;
        if (link.packet_valid)
        begin
            next_st.ok  = link.data_ok;
            next_st.cnt = link.sample_count;
            next_st.ts  = link.next_cycle_start_time;
            next_st.s0  = link.samples[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st <= '{default: '0};
        else
            st <= next_st;
    end

    assign link.master_time = st.mt;
    assign link.time_load   = st.load;
    assign pkt_strobe       = st.strobe;
    assign pkt_ok           = st.ok;
    assign pkt_count        = st.cnt;
    assign pkt_time         = st.ts;
    assign first_sample     = st.s0;
endmodule // bus_master

// [os_link_checker.sv]
// Checker: timing relations on the process data link
`timescale 1ns/1ps
module os_link_checker
    import oversampling_pkg::*;
(
    input wire logic                clk,                   // Clock
    input wire logic                rst,                   // Sync reset
    input wire logic                packet_valid,          // Publish pulse
    input wire logic                data_ok,               // Data valid
    input wire logic [FACTOR_W-1:0] sample_count,          // Samples in packet
    input wire sample_t             samples [MAX_FACTOR],  // Sample array
    input wire logic                stamp_valid,           // Stamp enabled
    input wire time_t               next_cycle_start_time, // Stamp
    input wire logic                time_load              // Realign pulse
);
    // ----
    // Packet spacing tracker
    // ----
    localparam int MIN_GAP = MIN_CYCLE_NS / CLK_PERIOD_NS;
    typedef struct packed {
        logic [31:0] gap;
        time_t       prev;
        logic        have;
    } aux_s;
    aux_s cur;
    aux_s next_cur;
    always_comb
    begin
        next_cur = cur;
        next_cur.gap = cur.gap + 32'h1;
        if (packet_valid)
        begin
            next_cur.gap = 32'h1;
            next_cur.prev = next_cycle_start_time;
            next_cur.have = 1'b1;
        end
        // Realign makes the time jump, so spacing restarts
        if (time_load)
            next_cur.have = 1'b0;
    end
    always_ff @(posedge clk)
        if (rst)
            cur <= '0;
        else
            cur <= next_cur;
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_PULSE: assert property (packet_valid |=> !packet_valid)
        else $error("packet pulse longer than one cycle");
    AST_DATA_OK: assert property (packet_valid |-> data_ok)
        else $error("packet published without valid data");
    AST_COUNT: assert property (packet_valid |-> sample_count inside {[7'h01:7'h64]})
        else $error("sample count out of range");
    AST_STAMP_OFF: assert property (!stamp_valid |-> next_cycle_start_time == '0)
        else $error("stamp present while disabled");
    AST_HELD: assert property (!packet_valid |-> $stable(next_cycle_start_time)
        && $stable(samples[0]))
        else $error("packet contents changed between publishes");
    AST_STEP: assert property (packet_valid && cur.have && stamp_valid |->
        next_cycle_start_time - cur.prev == TIME_STEP_NS * cur.gap)
        else $error("stamp step differs from packet spacing");
    AST_GAP_MIN: assert property (packet_valid && cur.have |-> cur.gap >= MIN_GAP)
        else $error("packets closer than minimum cycle");
    AST_TAIL: assert property (sample_count != 7'h64 |-> samples[MAX_FACTOR-1] == '0)
        else $error("unused slot not cleared");
    AST_LOAD_PULSE: assert property (time_load |=> !time_load)
        else $error("time load longer than one cycle");
endmodule // os_link_checker

// [tb_encoder_oversampling_buffer.sv]
// Testbench: capture node and bus master joined by the process data link
`timescale 1ns/1ps
module tb_encoder_oversampling_buffer;
    import oversampling_pkg::*;
    logic                clk = 1'b0;
    logic                rst = 1'b1;
    sample_t             counter = '0;
    logic [FACTOR_W-1:0] factor = FACTOR_RESET;
    logic [31:0]         cycle_ns = CYCLE_NS_RESET;
    logic                stamp_en = STAMP_EN_RESET;
    time_t               ref_time = 64'h0000_0001_0000_0000;
    logic                sync_req = 1'b0;
    logic                op_state;
    logic                pkt_strobe;
    logic                pkt_ok;
    logic [FACTOR_W-1:0] pkt_count;
    time_t               pkt_time;
    sample_t             first_sample;
    int                  mismatches = 0;
    int                  checked = 0;
    int                  ticks = 0;
    os_link_if i_os_link_if ();
    capture_node i_capture_node (.clk(clk), .rst(rst), .counter(counter), .factor(factor),
        .cycle_ns(cycle_ns), .stamp_en(stamp_en), .op_state(op_state),
        .link(i_os_link_if.node));
    bus_master i_bus_master (.clk(clk), .rst(rst), .ref_time(ref_time), .sync_req(sync_req),
        .pkt_strobe(pkt_strobe), .pkt_ok(pkt_ok), .pkt_count(pkt_count),
        .pkt_time(pkt_time), .first_sample(first_sample), .link(i_os_link_if.master));
    os_link_checker i_os_link_checker (.clk(clk), .rst(rst),
        .packet_valid(i_os_link_if.packet_valid), .data_ok(i_os_link_if.data_ok),
        .sample_count(i_os_link_if.sample_count), .samples(i_os_link_if.samples),
        .stamp_valid(i_os_link_if.stamp_valid), .time_load(i_os_link_if.time_load),
        .next_cycle_start_time(i_os_link_if.next_cycle_start_time));
    // ----
    // Clock, encoder counter and master reference time
    // ----
    always #50 clk = ~clk;
    always @(posedge clk) ticks <= ticks + 1;
    always @(negedge clk)
    begin
        counter <= counter + 32'h1;
        ref_time <= ref_time + TIME_STEP_NS;
    end
    // ----
    // Tasks
    // ----
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic start(input logic [31:0] cyc, input logic [6:0] n, input logic en);
        @(negedge clk);
        rst = 1'b1;
        cycle_ns = cyc;
        factor = n;
        stamp_en = en;
        repeat (12) @(negedge clk);
        check(i_os_link_if.sample_count, 64'h1);
        check(i_os_link_if.stamp_valid, 64'h1);
        rst = 1'b0;
        @(negedge clk);
        sync_req = 1'b1;
        @(negedge clk);
        sync_req = 1'b0;
    endtask
    task automatic wait_pkt(input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge clk);
            #1;
            if (i_os_link_if.packet_valid === 1'b1)
                return;
        end
        mismatches++;
        $display("ERROR at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask
    task automatic run_ok(input logic [31:0] cyc, input logic [6:0] n, input logic en);
        int p;
        int s;
        int c1;
        time_t t1;
        sample_t s0;
        p = cyc / 100;
        s = p / n;
        start(cyc, n, en);
        // First cycle after realign is never published
        wait_pkt(2 * p + 20);
        c1 = ticks;
        t1 = i_os_link_if.next_cycle_start_time;
        wait_pkt(p + 20);
        check(ticks - c1, p);
        check(op_state, 1);
        check(i_os_link_if.data_ok, 1);
        check(i_os_link_if.sample_count, n);
        s0 = i_os_link_if.samples[0];
        check(counter - s0 >= p && counter - s0 <= p + 3, 1);
        for (int i = 1; i < MAX_FACTOR; i++)
            check(i_os_link_if.samples[i], i < n ? s0 + i * s : 32'h0);
        if (en)
        begin
            check(i_os_link_if.next_cycle_start_time - t1, cyc);
            check(i_os_link_if.next_cycle_start_time > ref_time, 1);
            check(i_os_link_if.next_cycle_start_time <= ref_time + cyc, 1);
        end
        else
            check(i_os_link_if.next_cycle_start_time | i_os_link_if.stamp_valid, 0);
        @(posedge clk);
        #1;
        check(pkt_strobe, 1);
        check(pkt_ok, 1);
        check(pkt_count, n);
        check(pkt_time, en ? t1 + cyc : 64'h0);
        check(first_sample, s0);
    endtask
    task automatic run_bad(input logic [31:0] cyc, input logic [6:0] n);
        int seen;
        seen = 0;
        start(cyc, n, 1'b1);
        repeat (cyc / 50 + 20)
        begin
            @(posedge clk);
            #1;
            if (i_os_link_if.packet_valid !== 1'b0)
                seen++;
        end
        check(seen, 0);
        check(i_os_link_if.data_ok, 0);
        check(op_state, 1);
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        run_ok(32'h0007_a120, 7'h32, 1'b1);
        run_ok(32'h000f_4240, 7'h64, 1'b1);
        run_ok(32'h0007_a120, 7'h01, 1'b0);
        run_bad(32'h0007_a120, 7'h03);
        run_bad(32'h0007_a120, 7'h64);
        run_bad(32'h0006_1a80, 7'h01);
        results();
    end
endmodule // tb_encoder_oversampling_buffer
